// ### rtl/cidt_defs.svh
`ifndef CIDT_DEFS_SVH
`define CIDT_DEFS_SVH

// oscillator periods per instruction cycle
`define CIDT_QPHASES 4
// register byte offsets on the bus
`define CIDT_OFF_CTRL 8'h00
`define CIDT_OFF_STATUS 8'h04
`define CIDT_OFF_PC 8'h08
`define CIDT_OFF_INSTR 8'h0C
`define CIDT_OFF_CYCLES 8'h10
`define CIDT_OFF_ILLEGAL 8'h14
// control register fields and reset value
`define CIDT_CTRL_RUN 0
`define CIDT_CTRL_EXT 1
`define CIDT_CTRL_RESTART 2
`define CIDT_CTRL_RST 3'h1
// program counter reset vector, word address
`define CIDT_RESET_VECTOR 20'h00000
// access ram split: low part in bank 0, high part in the top bank
`define CIDT_ACCESS_SPLIT 8'h80
`define CIDT_ACCESS_LO_BANK 4'h0
`define CIDT_ACCESS_HI_BANK 4'hF
// word that stands in for a discarded fetch
`define CIDT_NOP_WORD 16'h0000
// top nibble of every second word of a double-word instruction
`define CIDT_SECOND_TAG 4'hF

`endif

// ### rtl/cidt_pkg.sv
package cidt_pkg;

  // instruction category of the word in execution
  typedef enum logic [2:0] {
    CIDT_CLS_NOP,
    CIDT_CLS_BYTE,
    CIDT_CLS_BIT,
    CIDT_CLS_LIT,
    CIDT_CLS_CTRL,
    CIDT_CLS_EXT,
    CIDT_CLS_ILLEGAL
  } cidt_cls_e;

  // table pointer handling for table read and write
  typedef enum logic [1:0] {
    CIDT_TBL_NONE,
    CIDT_TBL_POSTINC,
    CIDT_TBL_POSTDEC,
    CIDT_TBL_PREINC
  } cidt_tbl_e;

  // sequencer state: ordinary word or second word of a pair
  typedef enum logic {
    CIDT_ST_NORMAL,
    CIDT_ST_SECOND
  } cidt_st_e;

endpackage

// ### rtl/cidt_decode.sv
`timescale 1ns/10ps
`include "cidt_defs.svh"

// pure opcode classifier for one 16-bit program word
module cidt_decode (
  input wire logic [15:0] word,
  input wire logic ext_en,
  output cidt_pkg::cidt_cls_e cls,
  output logic two_word,
  output logic is_skip,
  output logic jmp_abs,
  output logic rel_long,
  output logic rel_cond,
  output logic is_ret,
  output logic fast,
  output cidt_pkg::cidt_tbl_e tbl_mode,
  output logic wr_res,
  output logic [1:0] ptr_sel
);
  import cidt_pkg::*;

  // map the two table mode bits onto the pointer action
  function automatic cidt_tbl_e tbl_of(input logic [1:0] mm);
    unique case (mm)
      2'h0: tbl_of = CIDT_TBL_NONE;
      2'h1: tbl_of = CIDT_TBL_POSTINC;
      2'h2: tbl_of = CIDT_TBL_POSTDEC;
      2'h3: tbl_of = CIDT_TBL_PREINC;
    endcase
  endfunction

  // opcode nibble picks the family, lower bits qualify it
  always_comb begin
    cls = CIDT_CLS_ILLEGAL;
    two_word = 1'b0;
    is_skip = 1'b0;
    jmp_abs = 1'b0;
    rel_long = 1'b0;
    rel_cond = 1'b0;
    is_ret = 1'b0;
    fast = word[0];
    tbl_mode = tbl_of(word[1:0]);
    wr_res = 1'b0;
    ptr_sel = word[5:4];
    unique case (word[15:12])
      4'h0: begin
        if (word[11:8] == 4'h0) begin
          if (word[7:0] == 8'h00) begin
            cls = CIDT_CLS_NOP;
          end else if (word[7:3] == 5'h01) begin
            cls = CIDT_CLS_CTRL;
          end else if (word[7:2] == 6'h04) begin
            cls = CIDT_CLS_CTRL;
            is_ret = 1'b1;
          end else if (word[7:0] == 8'h14) begin
            cls = ext_en ? CIDT_CLS_EXT : CIDT_CLS_ILLEGAL;
            is_ret = ext_en;
          end else if (word[7:0] >= 8'h03 && word[7:0] <= 8'h07 || word[7:0] == 8'hFF) begin
            cls = CIDT_CLS_CTRL;
          end
        end else if (word[11:4] == 8'h10) begin
          cls = CIDT_CLS_LIT;
        end else if (word[11:9] == 3'h1) begin
          cls = CIDT_CLS_BYTE;
        end else if (word[11]) begin
          cls = CIDT_CLS_LIT;
          is_ret = (word[11:8] == 4'hC);
        end
      end
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5: begin
        cls = CIDT_CLS_BYTE;
        wr_res = 1'b1;
        is_skip = (word[15:12] == 4'h2 || word[15:12] == 4'h3) && (word[11:10] == 2'h3)
                  || (word[15:12] == 4'h4) && word[11];
      end
      4'h6: begin
        cls = CIDT_CLS_BYTE;
        is_skip = ~word[11];
      end
      4'h7, 4'h8, 4'h9: begin
        cls = CIDT_CLS_BIT;
      end
      4'hA, 4'hB: begin
        cls = CIDT_CLS_BIT;
        is_skip = 1'b1;
      end
      4'hC: begin
        cls = CIDT_CLS_BYTE;
        two_word = 1'b1;
      end
      4'hD: begin
        cls = CIDT_CLS_CTRL;
        rel_long = 1'b1;
      end
      4'hE: begin
        if (!word[11]) begin
          cls = CIDT_CLS_CTRL;
          rel_cond = 1'b1;
        end else if (word[11:9] == 3'h6) begin
          cls = CIDT_CLS_CTRL;
          two_word = 1'b1;
          jmp_abs = 1'b1;
          fast = word[8];
        end else if (word[11:8] == 4'hE) begin
          if (word[7:6] == 2'h0) begin
            cls = CIDT_CLS_LIT;
            two_word = 1'b1;
          end
        end else if (word[11:8] == 4'hF) begin
          cls = CIDT_CLS_CTRL;
          two_word = 1'b1;
          jmp_abs = 1'b1;
        end else if (ext_en) begin
          cls = CIDT_CLS_EXT;
          ptr_sel = word[7:6];
          two_word = (word[11:8] == 4'hB);
        end
      end
      4'hF: begin
        cls = CIDT_CLS_NOP;
      end
    endcase
  end

endmodule

// ### rtl/cidt_core.sv
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "cidt_defs.svh"

// Overview of operation
// - recognise standard set plus optional extended group
// - one word each, four instructions use two, five with the extended group on
// - split word into opcode and operand fields
// - byte ops carry file, destination, access selectors
// - destination zero accumulator, one file register
// - bit ops select bit number in file
// - literal ops take constant, pointer, or nothing
// - second word tagged ones, alone a nop
// - one cycle, two when skipped or redirected
// - double-word instructions take two cycles
// - instruction cycle is four oscillator periods
// - true skip over pair costs three cycles
// - access selector picks access ram or bank
// - table mode chooses pointer update kind
// - fast mode bit saves or restores shadows
// - file field is address or pointer designator
module cidt_core #(
  parameter int PC_W = 20
) (
  input wire logic sys_clk,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // program memory fetch
  output logic fetch_req,
  output logic [PC_W:0] fetch_addr,
  input wire logic [15:0] fetch_word,
  // datapath side
  input wire logic cond_true,
  input wire logic [PC_W-1:0] alt_target,
  input wire logic [3:0] bank_select_register,
  output logic [1:0] iq_phase,
  output logic ex_start,
  output logic [15:0] ex_instr,
  output cidt_pkg::cidt_cls_e ex_cls,
  output logic ex_nop,
  output logic ex_second,
  output logic [11:0] ex_ram_addr,
  output logic ex_wr_accum,
  output logic ex_wr_file,
  output logic [2:0] ex_bit_num,
  output logic [7:0] ex_literal,
  output logic [1:0] ex_ptr_sel,
  output logic ex_fast,
  output cidt_pkg::cidt_tbl_e ex_tbl_mode,
  output logic [11:0] ex_long_operand,
  output logic [PC_W-1:0] ex_pc
);
  import cidt_pkg::*;

  localparam logic [1:0] Q_LAST = 2'(`CIDT_QPHASES - 1);

  // goto and call targets are 20 bits wide
  initial begin
    if (PC_W < 20 || PC_W > 31) begin
      $error("cidt_core: PC_W must lie in 20..31");
    end
  end

  // software control and sequencer state
  logic [2:0] ctrl_r;
  logic restart_r;
  logic [1:0] q_r;
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [15:0] ir_r;
  cidt_st_e st_r;
  logic kill_r;
  logic kill_nxt;
  logic [31:0] cycles_r;
  logic [31:0] illegal_r;
  logic run;
  logic tick;
  // latched decode of the word in execution, only acted on when cur_valid
  logic cur_two_r;
  logic cur_skip_r;
  logic cur_jmp_r;
  logic cur_rel_long_r;
  logic cur_rel_cond_r;
  logic cur_ret_r;
  logic cur_valid;
  logic go_second;
  // decoder outputs for the word arriving from memory
  cidt_cls_e d_cls;
  logic d_two;
  logic d_skip;
  logic d_jmp;
  logic d_rel_long;
  logic d_rel_cond;
  logic d_ret;
  logic d_fast;
  cidt_tbl_e d_tbl;
  logic d_wr_res;
  logic [1:0] d_ptr;
  // bus pipeline
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic bus_take;

  cidt_decode u_decode (
    .word(fetch_word),
    .ext_en(ctrl_r[`CIDT_CTRL_EXT]),
    .cls(d_cls),
    .two_word(d_two),
    .is_skip(d_skip),
    .jmp_abs(d_jmp),
    .rel_long(d_rel_long),
    .rel_cond(d_rel_cond),
    .is_ret(d_ret),
    .fast(d_fast),
    .tbl_mode(d_tbl),
    .wr_res(d_wr_res),
    .ptr_sel(d_ptr)
  );

  // access selector: low access ram, high special bank, or banked
  function automatic logic [11:0] ram_addr_of(input logic banked, input logic [3:0] bank,
                                              input logic [7:0] f);
    if (banked) begin
      ram_addr_of = {bank, f};
    end else if (f < `CIDT_ACCESS_SPLIT) begin
      ram_addr_of = {`CIDT_ACCESS_LO_BANK, f};
    end else begin
      ram_addr_of = {`CIDT_ACCESS_HI_BANK, f};
    end
  endfunction

  assign run = ctrl_r[`CIDT_CTRL_RUN];
  assign tick = run && (q_r == Q_LAST);
  assign cur_valid = !kill_r && (st_r == CIDT_ST_NORMAL);
  assign go_second = cur_valid && cur_two_r;

  // phase counter: four oscillator periods per instruction cycle
  // restart realigns the phase so a new program starts on a clean cycle
  always_ff @(posedge sys_clk) begin
    if (!rstn || restart_r) begin
      q_r <= 2'h0;
    end else if (run) begin
      q_r <= (q_r == Q_LAST) ? 2'h0 : q_r + 2'h1;
    end
  end

  // next fetch address and whether the prefetched word survives
  always_comb begin
    pc_nxt = pc_r + PC_W'(1);
    kill_nxt = 1'b0;
    if (go_second && cur_jmp_r) begin
      // second word is in hand now, so the jump costs no flush cycle
      pc_nxt = PC_W'({fetch_word[11:0], ex_literal});
    end else if (cur_valid && cur_rel_long_r) begin
      // pc already stands one word past the branch
      pc_nxt = pc_r + {{(PC_W - 11){ir_r[10]}}, ir_r[10:0]};
      kill_nxt = 1'b1;
    end else if (cur_valid && cur_rel_cond_r && cond_true) begin
      pc_nxt = pc_r + {{(PC_W - 8){ir_r[7]}}, ir_r[7:0]};
      kill_nxt = 1'b1;
    end else if (cur_valid && cur_ret_r) begin
      // the return address comes back from the datapath's stack
      pc_nxt = alt_target;
      kill_nxt = 1'b1;
    end else if (cur_valid && cur_skip_r && cond_true) begin
      // a skipped pair's second word then runs as a nop: three cycles
      kill_nxt = 1'b1;
    end
  end

  // program counter, one word ahead of the word in execution
  always_ff @(posedge sys_clk) begin
    if (!rstn || restart_r) begin
      pc_r <= PC_W'(`CIDT_RESET_VECTOR);
      ex_pc <= PC_W'(`CIDT_RESET_VECTOR);
    end else if (tick) begin
      pc_r <= pc_nxt;
      ex_pc <= pc_r;
    end
  end

  // instruction register and sequencer state
  always_ff @(posedge sys_clk) begin
    if (!rstn || restart_r) begin
      ir_r <= `CIDT_NOP_WORD;
      st_r <= CIDT_ST_NORMAL;
      kill_r <= 1'b1;
    end else if (tick) begin
      kill_r <= kill_nxt;
      st_r <= go_second ? CIDT_ST_SECOND : CIDT_ST_NORMAL;
      // a pair's first word stays on show through its tail cycle
      if (!go_second) begin
        ir_r <= kill_nxt ? `CIDT_NOP_WORD : fetch_word;
      end
    end
  end

  // control flags of the word in execution; cleared for a pair's tail
  // the tail's bits are operand data and must never steer the sequencer
  always_ff @(posedge sys_clk) begin
    if (!rstn || restart_r) begin
      cur_two_r <= 1'b0;
      cur_skip_r <= 1'b0;
      cur_jmp_r <= 1'b0;
      cur_rel_long_r <= 1'b0;
      cur_rel_cond_r <= 1'b0;
      cur_ret_r <= 1'b0;
    end else if (tick) begin
      cur_two_r <= !go_second && d_two;
      cur_skip_r <= !go_second && d_skip;
      cur_jmp_r <= !go_second && d_jmp;
      cur_rel_long_r <= !go_second && d_rel_long;
      cur_rel_cond_r <= !go_second && d_rel_cond;
      cur_ret_r <= !go_second && d_ret;
    end
  end

  // operand fields to the datapath; all but ex_long_operand held through a pair's second cycle
  always_ff @(posedge sys_clk) begin
    if (!rstn || restart_r) begin
      ex_cls <= CIDT_CLS_NOP;
      ex_ram_addr <= 12'h000;
      ex_wr_accum <= 1'b0;
      ex_wr_file <= 1'b0;
      ex_bit_num <= 3'h0;
      ex_literal <= 8'h00;
      ex_ptr_sel <= 2'h0;
      ex_fast <= 1'b0;
      ex_tbl_mode <= CIDT_TBL_NONE;
      ex_long_operand <= 12'h000;
    end else if (tick && go_second) begin
      ex_long_operand <= fetch_word[11:0];
    end else if (tick) begin
      ex_cls <= kill_nxt ? CIDT_CLS_NOP : d_cls;
      // bank is sampled with the word, so a later bank change cannot tear it
      ex_ram_addr <= ram_addr_of(fetch_word[8], bank_select_register, fetch_word[7:0]);
      ex_wr_accum <= !kill_nxt && d_wr_res && !fetch_word[9];
      ex_wr_file <= !kill_nxt && d_wr_res && fetch_word[9];
      ex_bit_num <= fetch_word[11:9];
      ex_literal <= fetch_word[7:0];
      ex_ptr_sel <= d_ptr;
      ex_fast <= d_fast;
      ex_tbl_mode <= d_tbl;
      ex_long_operand <= 12'h000;
    end
  end

  // activity and illegal-word counters; a counter write clears it
  // clear beats count in one cycle: these are software tallies, not flags
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cycles_r <= 32'h0000_0000;
      illegal_r <= 32'h0000_0000;
    end else begin
      if (wr_pend_r && wr_addr_r == `CIDT_OFF_CYCLES) begin
        cycles_r <= 32'h0000_0000;
      end else if (tick) begin
        cycles_r <= cycles_r + 32'h0000_0001;
      end
      if (wr_pend_r && wr_addr_r == `CIDT_OFF_ILLEGAL) begin
        illegal_r <= 32'h0000_0000;
      end else if (tick && cur_valid && ex_cls == CIDT_CLS_ILLEGAL) begin
        illegal_r <= illegal_r + 32'h0000_0001;
      end
    end
  end

  // fetch strobe at the first phase; address stands the whole cycle
  // program memory has until the phase-3 edge to answer
  assign fetch_req = run && (q_r == 2'h0);
  assign fetch_addr = {pc_r, 1'b0};
  assign iq_phase = q_r;
  // the datapath starts as the next fetch goes out
  assign ex_start = run && (q_r == 2'h0);
  assign ex_instr = ir_r;
  assign ex_second = (st_r == CIDT_ST_SECOND);
  // discarded words, pair tails and unknown codes do nothing
  assign ex_nop = kill_r
                  || ex_second
                  || (ex_cls == CIDT_CLS_NOP)
                  || (ex_cls == CIDT_CLS_ILLEGAL);

  // zero-wait slave: never stretches, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign bus_take = hsel && hready && htrans[1];

  // address phase of a write; data follows next cycle
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= bus_take && hwrite;
      // loaded every cycle; only wr_pend_r gives it meaning
      wr_addr_r <= haddr[7:0];
    end
  end

  // control register; restart is a self-clearing strobe
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl_r <= `CIDT_CTRL_RST;
      restart_r <= 1'b0;
    end else begin
      restart_r <= 1'b0;
      if (wr_pend_r && wr_addr_r == `CIDT_OFF_CTRL) begin
        ctrl_r <= {1'b0, hwdata[`CIDT_CTRL_EXT], hwdata[`CIDT_CTRL_RUN]};
        // restart is never stored, so it always reads back as zero
        restart_r <= hwdata[`CIDT_CTRL_RESTART];
      end
    end
  end

  // read data captured in the address phase, so it stands in the data phase
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_take && !hwrite) begin
      unique case (haddr[7:0])
        `CIDT_OFF_CTRL: hrdata <= {29'h0, ctrl_r};
        `CIDT_OFF_STATUS: hrdata <= {23'h0, run, ex_cls, cur_two_r, ex_nop, ex_second, q_r};
        `CIDT_OFF_PC: hrdata <= 32'(ex_pc);
        `CIDT_OFF_INSTR: hrdata <= {16'h0, ir_r};
        `CIDT_OFF_CYCLES: hrdata <= cycles_r;
        `CIDT_OFF_ILLEGAL: hrdata <= illegal_r;
        // unmapped offsets read zero instead of erroring
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ### bench/cidt_core_asserts.sv
`timescale 1ns/10ps
`include "cidt_defs.svh"

// watches the execute-stage outputs of the core for field and timing slips
module cidt_core_asserts #(
  parameter int PC_W = 20
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic fetch_req,
  input wire logic [PC_W:0] fetch_addr,
  input wire logic [1:0] iq_phase,
  input wire logic ex_start,
  input wire logic [15:0] ex_instr,
  input wire cidt_pkg::cidt_cls_e ex_cls,
  input wire logic ex_nop,
  input wire logic ex_second,
  input wire logic [11:0] ex_ram_addr,
  input wire logic ex_wr_accum,
  input wire logic ex_wr_file,
  input wire logic [2:0] ex_bit_num,
  input wire logic [7:0] ex_literal,
  input wire cidt_pkg::cidt_tbl_e ex_tbl_mode
);
  import cidt_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // pair tail spans exactly one instruction cycle of four clocks
  sequence s_tail;
    ex_second [*4];
  endsequence
  sequence s_tail_end;
    !ex_second;
  endsequence

  // restart may pull the phase back to zero, so only forward steps are judged
  property p_phase;
    $past(rstn) && iq_phase != 2'h0 |-> iq_phase == $past(iq_phase) + 2'h1 || $stable(iq_phase);
  endproperty
  a_phase: assert property (p_phase) else $error("phase skipped");
  property p_start;
    ex_start |-> iq_phase == 2'h0 && fetch_req;
  endproperty
  a_start: assert property (p_start) else $error("start off phase zero");
  property p_fetch;
    fetch_req |-> iq_phase == 2'h0 && fetch_addr[0] == 1'b0;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not word aligned");
  property p_dest_a;
    ex_wr_accum |-> !ex_wr_file && !ex_instr[9] && ex_cls == CIDT_CLS_BYTE;
  endproperty
  a_dest_a: assert property (p_dest_a) else $error("accumulator write wrong");
  property p_dest_f;
    ex_wr_file |-> ex_instr[9] && !ex_nop;
  endproperty
  a_dest_f: assert property (p_dest_f) else $error("file write wrong");
  property p_bank;
    ex_cls == CIDT_CLS_BYTE && !ex_instr[8] && ex_instr[15:12] != 4'hC |->
      ex_ram_addr == {(ex_instr[7:0] < `CIDT_ACCESS_SPLIT) ? `CIDT_ACCESS_LO_BANK :
      `CIDT_ACCESS_HI_BANK, ex_instr[7:0]};
  endproperty
  a_bank: assert property (p_bank) else $error("access ram address wrong");
  property p_bit;
    ex_cls == CIDT_CLS_BIT |-> ex_bit_num == ex_instr[11:9] && ex_ram_addr[7:0] == ex_instr[7:0];
  endproperty
  a_bit: assert property (p_bit) else $error("bit fields wrong");
  property p_lit;
    ex_cls == CIDT_CLS_LIT |-> ex_literal == ex_instr[7:0];
  endproperty
  a_lit: assert property (p_lit) else $error("literal wrong");
  property p_tbl;
    ex_instr[15:2] == 14'h0002 && !ex_nop |-> ex_tbl_mode == cidt_tbl_e'(ex_instr[1:0]);
  endproperty
  a_tbl: assert property (p_tbl) else $error("table mode wrong");
  property p_tail;
    $rose(ex_second) |-> s_tail ##1 s_tail_end;
  endproperty
  a_tail: assert property (p_tail) else $error("pair tail length wrong");
  property p_tail_nop;
    ex_second |-> ex_nop;
  endproperty
  a_tail_nop: assert property (p_tail_nop) else $error("second word not a nop");
endmodule

bind cidt_core cidt_core_asserts #(.PC_W(PC_W)) u_asserts (
  .sys_clk(sys_clk), .rstn(rstn), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
  .iq_phase(iq_phase), .ex_start(ex_start), .ex_instr(ex_instr), .ex_cls(ex_cls),
  .ex_nop(ex_nop), .ex_second(ex_second), .ex_ram_addr(ex_ram_addr),
  .ex_wr_accum(ex_wr_accum), .ex_wr_file(ex_wr_file), .ex_bit_num(ex_bit_num),
  .ex_literal(ex_literal), .ex_tbl_mode(ex_tbl_mode)
);

// ### bench/core_instruction_decode_timing_test.sv
`timescale 1ns/10ps
`include "cidt_defs.svh"

module core_instruction_decode_timing_test;
  import cidt_pkg::*;
  logic sys_clk, rstn, hsel, hwrite, cond_true, hreadyout, hresp, fetch_req, ex_start;
  logic ex_nop, ex_second, ex_wr_accum, ex_wr_file, ex_fast;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, iq_phase, ex_ptr_sel;
  logic [2:0] hsize, ex_bit_num;
  logic [3:0] bank_select_register;
  logic [20:0] fetch_addr;
  logic [19:0] alt_target, ex_pc;
  logic [15:0] fetch_word, ex_instr;
  logic [11:0] ex_ram_addr, ex_long_operand;
  logic [7:0] ex_literal;
  cidt_cls_e ex_cls;
  cidt_tbl_e ex_tbl_mode;
  logic [15:0] rom [0:63];
  int fail_count, checks_done, cyc, gap;
  localparam logic [15:0] PROG [0:11] = '{16'h2625, 16'h2490, 16'h2533, 16'h8A10,
    16'h0E5A, 16'hEE21, 16'hF023, 16'h0008, 16'h0009, 16'h000A, 16'h000B, 16'h0013};

  cidt_core #(.PC_W(20)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_word(fetch_word), .cond_true(cond_true),
    .alt_target(alt_target), .bank_select_register(bank_select_register),
    .iq_phase(iq_phase), .ex_start(ex_start), .ex_instr(ex_instr), .ex_cls(ex_cls),
    .ex_nop(ex_nop), .ex_second(ex_second), .ex_ram_addr(ex_ram_addr),
    .ex_wr_accum(ex_wr_accum), .ex_wr_file(ex_wr_file), .ex_bit_num(ex_bit_num),
    .ex_literal(ex_literal), .ex_ptr_sel(ex_ptr_sel), .ex_fast(ex_fast),
    .ex_tbl_mode(ex_tbl_mode), .ex_long_operand(ex_long_operand), .ex_pc(ex_pc));

  // clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      final_report();
    end
  end
  // program memory answers well before the phase-3 sampling edge
  always @(posedge sys_clk) fetch_word <= rom[fetch_addr[6:1]];

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // advance to the next instruction cycle; gap counts its clocks
  task automatic step();
    gap = 0;
    do begin
      @(posedge sys_clk);
      #1;
      gap++;
    end while (ex_start !== 1'b1 && gap < 20);
  endtask
  // ffff stands for a word whose shown value is left open
  task automatic ex_is(input logic [15:0] w, input logic nop);
    step();
    check(gap, 32'h4);
    if (w !== 16'hFFFF) check(32'(ex_instr), 32'(w));
    check(32'(ex_nop), 32'(nop));
  endtask

  // two leading nops keep the pre-restart pass away from the program
  task automatic t_setup();
    ahb(1'b1, 32'(`CIDT_OFF_CTRL), 32'h7);
    ahb(1'b0, 32'(`CIDT_OFF_CTRL), 32'h0);
    check(rd, 32'h3);
    ahb(1'b0, 32'h40, 32'h0);
    check(rd, 32'h0);
    for (int i = 0; i < 40 && ex_instr !== 16'h2625; i++) step();
  endtask
  task automatic t_byte();
    check(32'(ex_cls), 32'(CIDT_CLS_BYTE));
    check(32'(ex_wr_file), 32'h1);
    check(32'(ex_ram_addr), 32'h025);
    ex_is(16'h2490, 1'b0);
    check(32'(ex_wr_accum), 32'h1);
    check(32'(ex_ram_addr), 32'hF90);
    ex_is(16'h2533, 1'b0);
    check(32'(ex_ram_addr), 32'h533);
  endtask
  task automatic t_bitlit();
    ex_is(16'h8A10, 1'b0);
    check(32'(ex_bit_num), 32'h5);
    ex_is(16'h0E5A, 1'b0);
    check(32'(ex_cls), 32'(CIDT_CLS_LIT));
    check(32'(ex_literal), 32'h5A);
  endtask
  task automatic t_pair();
    ex_is(16'hEE21, 1'b0);
    check(32'(ex_ptr_sel), 32'h2);
    ex_is(16'hEE21, 1'b1);
    check(32'(ex_second), 32'h1);
    check(32'(ex_long_operand), 32'h023);
  endtask
  task automatic t_table();
    for (int i = 0; i < 4; i++) begin
      ex_is(16'(16'h0008 + i), 1'b0);
      check(32'(ex_tbl_mode), 32'(i));
    end
  endtask
  // return, goto, a taken skip over a pair, then a long branch
  task automatic t_redirect();
    ex_is(16'h0013, 1'b0);
    check(32'(ex_fast), 32'h1);
    ex_is(`CIDT_NOP_WORD, 1'b1);
    ex_is(16'hEF22, 1'b0);
    ex_is(16'hEF22, 1'b1);
    ex_is(16'hB000, 1'b0);
    ex_is(`CIDT_NOP_WORD, 1'b1);
    ex_is(16'hF123, 1'b1);
    ex_is(16'hE8C5, 1'b0);
    check(32'(ex_cls), 32'(CIDT_CLS_EXT));
    check(32'(ex_ptr_sel), 32'h3);
    ex_is(16'hD003, 1'b0);
    ex_is(`CIDT_NOP_WORD, 1'b1);
    ex_is(16'h0E77, 1'b0);
    check(32'(ex_literal), 32'h77);
    check(32'(ex_pc), 32'h2A);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // datapath answers are held steady so every cycle is predictable
  initial begin
    {rstn, hsel, hwrite, haddr, hwdata, htrans, fetch_word} = '0;
    hsize = 3'h2;
    cond_true = 1'b1;
    alt_target = 20'd18;
    bank_select_register = 4'h5;
    for (int i = 0; i < 64; i++) rom[i] = 16'h0000;
    for (int i = 0; i < 12; i++) rom[i + 2] = PROG[i];
    rom[18] = 16'hEF22;
    rom[19] = 16'hF000;
    rom[34] = 16'hB000;
    rom[35] = 16'hC012;
    rom[36] = 16'hF123;
    rom[37] = 16'hE8C5;
    rom[38] = 16'hD003;
    rom[42] = 16'h0E77;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    t_setup();
    t_byte();
    t_bitlit();
    t_pair();
    t_table();
    t_redirect();
    final_report();
  end
endmodule
